// *** rtl/rtc_pkg.sv ***
// constants for the bcd calendar clock: offsets, field positions, resets.
// assumes a 32-bit classic wishbone slave and one 10 MHz clock.
package rtc_pkg;
  // byte offsets, one aligned word each
  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_HOUR_MODE = 6'h04;
  localparam logic [5:0] OFS_TIME = 6'h08;
  localparam logic [5:0] OFS_CAL = 6'h0c;
  localparam logic [5:0] OFS_TIME_ALARM = 6'h10;
  localparam logic [5:0] OFS_CAL_ALARM = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_STATUS_CLEAR = 6'h1c;
  localparam logic [5:0] OFS_IRQ_SET = 6'h20;
  localparam logic [5:0] OFS_IRQ_CLEAR = 6'h24;
  localparam logic [5:0] OFS_IRQ_STATE = 6'h28;
  localparam logic [5:0] OFS_ENTRY_ERR = 6'h2c;
  // mode and hour mode register fields
  localparam int TIME_UPD_BIT = 0;
  localparam int CAL_UPD_BIT = 1;
  localparam int TEV_SEL_LSB = 8;
  localparam int CEV_SEL_LSB = 16;
  localparam int HOUR_FMT_BIT = 0;
  // time and time alarm fields
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HOUR_LSB = 16;
  localparam int HALF_DAY_BIT = 22;
  localparam int SEC_EN_BIT = 7;
  localparam int MIN_EN_BIT = 15;
  localparam int HOUR_EN_BIT = 23;
  // calendar and calendar alarm fields
  localparam int CENTURY_FIELD_LSB = 0;
  localparam int YEAR_LSB = 8;
  localparam int MONTH_LSB = 16;
  localparam int DAY_LSB = 21;
  localparam int DATE_LSB = 24;
  localparam int MONTH_EN_BIT = 23;
  localparam int DATE_EN_BIT = 31;
  // status / mask bits
  localparam int ST_ACK = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_SEC = 2;
  localparam int ST_TIME_EVENT_FLAG = 3;
  localparam int ST_CALENDAR_EVENT_FLAG = 4;
  // entry error bits
  localparam int ERR_TIME = 0;
  localparam int ERR_CAL = 1;
  localparam int ERR_TIME_ALARM = 2;
  localparam int ERR_CAL_ALARM = 3;
  // reset values
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  localparam logic [31:0] CAL_RESET = 32'h01819819;
  // timing
  localparam int CLOCK_HZ = 10000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int SECOND_CYCLES = CLOCK_HZ * TICK_PERIOD_S;
endpackage

// *** rtl/bcd_calendar_clock_alarm.sv ***
// bcd calendar clock with alarm, events and entry checking.
// assumes a classic wishbone master on clock_i; seconds come from a divider.
`timescale 1ns/100ps
module bcd_calendar_clock_alarm #(
  parameter int SECOND_CYCLES = rtc_pkg::SECOND_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);

  typedef struct packed {
    logic [31:0] div;
    logic time_req;
    logic cal_req;
    logic [1:0] tev_sel;
    logic [1:0] cev_sel;
    logic hour_fmt;
    logic time_stop;
    logic cal_stop;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] century_field;
    logic [7:0] year;
    logic [7:0] month;
    logic [2:0] day;
    logic [7:0] date;
    logic [7:0] al_sec;
    logic [7:0] al_min;
    logic [7:0] al_hour;
    logic al_pm;
    logic al_sec_en;
    logic al_min_en;
    logic al_hour_en;
    logic [7:0] al_month;
    logic [7:0] al_date;
    logic al_month_en;
    logic al_date_en;
    logic [4:0] status;
    logic [4:0] mask;
    logic [3:0] err;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s q;
  state_s n;

  // bcd step with digit carry
  function automatic logic [7:0] bcd_inc(input logic [7:0] x);
    if (x[3:0] == 4'h9)
      bcd_inc = {x[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {x[7:4], x[3:0] + 4'h1};
  endfunction

  function automatic logic bcd_rng(input logic [7:0] x, input logic [7:0] lo,
                                   input logic [7:0] hi);
    bcd_rng = (x[3:0] <= 4'h9) && (x[7:4] <= 4'h9) && (x >= lo) && (x <= hi);
  endfunction

  // divisible by four, checked on the two bcd digits
  function automatic logic leap(input logic [7:0] y);
    if (y[4])
      leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] days_in(input logic [7:0] m,
                                         input logic [7:0] y);
    unique case (m)
      8'h02: days_in = leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default: days_in = 8'h31;
    endcase
  endfunction

  function automatic logic hour_ok(input logic [7:0] h, input logic pm,
                                   input logic fmt12);
    if (fmt12)
      hour_ok = bcd_rng(h, 8'h01, 8'h12);
    else
      hour_ok = bcd_rng(h, 8'h00, 8'h23) && !pm;
  endfunction

  // 12-hour entry to 24-hour bcd; only hours 01..11 pm need the add
  function automatic logic [7:0] to_24(input logic [7:0] h, input logic pm,
                                       input logic fmt12);
    logic [6:0] b;
    b = 7'(h[7:4]) * 7'd10 + 7'(h[3:0]) + 7'd12;
    if (!fmt12)
      to_24 = h;
    else if (h == 8'h12)
      to_24 = pm ? 8'h12 : 8'h00;
    else if (!pm)
      to_24 = h;
    else
      to_24 = {4'(b / 7'd10), 4'(b % 7'd10)};
  endfunction

  logic req, tick, time_run, cal_run, min_ch, hour_ch, midnight, noon;
  logic day_adv, month_ch, year_ch, tev_hit, cev_hit, al_hit, al_any;
  logic [4:0] st_set, st_clr;
  logic [31:0] rd_val, bmask, w;
  logic [7:0] wh, wdate, wmonth, wyear, wcent;
  logic [2:0] wday;
  logic cal_ok;

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign tick = (q.div == 32'(SECOND_CYCLES - 1));
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                  {8{wb_sel_i[0]}}};
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign irq_o = |(q.status & q.mask);

  // readback of the addressed word; also the base for byte-lane merges
  always_comb
  begin
    rd_val = 32'h0;
    unique case (wb_adr_i[5:2])
      rtc_pkg::OFS_MODE[5:2]:
      begin
        rd_val[rtc_pkg::TIME_UPD_BIT] = q.time_req;
        rd_val[rtc_pkg::CAL_UPD_BIT] = q.cal_req;
        rd_val[rtc_pkg::TEV_SEL_LSB +: 2] = q.tev_sel;
        rd_val[rtc_pkg::CEV_SEL_LSB +: 2] = q.cev_sel;
      end
      rtc_pkg::OFS_HOUR_MODE[5:2]: rd_val[rtc_pkg::HOUR_FMT_BIT] = q.hour_fmt;
      rtc_pkg::OFS_TIME[5:2]:
      begin
        rd_val[rtc_pkg::SEC_LSB +: 7] = q.sec[6:0];
        rd_val[rtc_pkg::MIN_LSB +: 7] = q.min[6:0];
        rd_val[rtc_pkg::HOUR_LSB +: 6] = q.hour[5:0];
        rd_val[rtc_pkg::HALF_DAY_BIT] = q.hour_fmt && (q.hour >= 8'h12);
      end
      rtc_pkg::OFS_CAL[5:2]:
      begin
        rd_val[rtc_pkg::CENTURY_FIELD_LSB +: 7] = q.century_field[6:0];
        rd_val[rtc_pkg::YEAR_LSB +: 8] = q.year;
        rd_val[rtc_pkg::MONTH_LSB +: 5] = q.month[4:0];
        rd_val[rtc_pkg::DAY_LSB +: 3] = q.day;
        rd_val[rtc_pkg::DATE_LSB +: 6] = q.date[5:0];
      end
      rtc_pkg::OFS_TIME_ALARM[5:2]:
      begin
        rd_val[rtc_pkg::SEC_LSB +: 7] = q.al_sec[6:0];
        rd_val[rtc_pkg::SEC_EN_BIT] = q.al_sec_en;
        rd_val[rtc_pkg::MIN_LSB +: 7] = q.al_min[6:0];
        rd_val[rtc_pkg::MIN_EN_BIT] = q.al_min_en;
        rd_val[rtc_pkg::HOUR_LSB +: 6] = q.al_hour[5:0];
        rd_val[rtc_pkg::HALF_DAY_BIT] = q.al_pm;
        rd_val[rtc_pkg::HOUR_EN_BIT] = q.al_hour_en;
      end
      rtc_pkg::OFS_CAL_ALARM[5:2]:
      begin
        rd_val[rtc_pkg::MONTH_LSB +: 5] = q.al_month[4:0];
        rd_val[rtc_pkg::MONTH_EN_BIT] = q.al_month_en;
        rd_val[rtc_pkg::DATE_LSB +: 6] = q.al_date[5:0];
        rd_val[rtc_pkg::DATE_EN_BIT] = q.al_date_en;
      end
      rtc_pkg::OFS_STATUS[5:2]: rd_val[4:0] = q.status;
      rtc_pkg::OFS_IRQ_STATE[5:2]: rd_val[4:0] = q.mask;
      rtc_pkg::OFS_ENTRY_ERR[5:2]: rd_val[3:0] = q.err;
      default: rd_val = 32'h0;
    endcase
  end

  always_comb
  begin
    n = q;
    w = (rd_val & ~bmask) | (wb_dat_i & bmask);
    st_set = 5'h0;
    st_clr = 5'h0;
    n.ack = req;
    n.rdata = req ? rd_val : q.rdata;
    n.div = tick ? 32'h0 : q.div + 32'h1;
    time_run = tick && !q.time_req;
    cal_run = !q.cal_req;
    min_ch = time_run && (q.sec == 8'h59);
    hour_ch = min_ch && (q.min == 8'h59);
    midnight = hour_ch && (q.hour == 8'h23);
    noon = hour_ch && (q.hour == 8'h11);
    day_adv = midnight && cal_run;
    month_ch = day_adv && (q.date == days_in(q.month, q.year));
    year_ch = month_ch && (q.month == 8'h12);
    // counters advance on the one-second enable
    if (time_run)
    begin
      n.sec = (q.sec == 8'h59) ? 8'h00 : bcd_inc(q.sec);
      if (min_ch)
        n.min = (q.min == 8'h59) ? 8'h00 : bcd_inc(q.min);
      if (hour_ch)
        n.hour = (q.hour == 8'h23) ? 8'h00 : bcd_inc(q.hour);
    end
    if (day_adv)
    begin
      n.day = (q.day == 3'h7) ? 3'h1 : q.day + 3'h1;
      n.date = month_ch ? 8'h01 : bcd_inc(q.date);
    end
    if (month_ch)
      n.month = year_ch ? 8'h01 : bcd_inc(q.month);
    if (year_ch)
    begin
      n.year = (q.year == 8'h99) ? 8'h00 : bcd_inc(q.year);
      if (q.year == 8'h99)
        n.century_field = (q.century_field == 8'h19) ? 8'h20 : 8'h19;
    end
    // events
    unique case (q.tev_sel)
      2'b00: tev_hit = min_ch;
      2'b01: tev_hit = hour_ch;
      2'b10: tev_hit = midnight;
      2'b11: tev_hit = noon;
    endcase
    unique case (q.cev_sel)
      2'b00: cev_hit = day_adv && (n.day == 3'h1);
      2'b01: cev_hit = month_ch;
      2'b10: cev_hit = year_ch;
      2'b11: cev_hit = 1'b0;
    endcase
    // alarm compares the freshly stepped counters
    al_any = q.al_sec_en || q.al_min_en || q.al_hour_en || q.al_month_en ||
             q.al_date_en;
    al_hit = time_run && al_any &&
             (!q.al_sec_en || (n.sec == q.al_sec)) &&
             (!q.al_min_en || (n.min == q.al_min)) &&
             (!q.al_hour_en ||
              (n.hour == to_24(q.al_hour, q.al_pm, q.hour_fmt))) &&
             (!q.al_month_en || (n.month == q.al_month)) &&
             (!q.al_date_en || (n.date == q.al_date));
    st_set[rtc_pkg::ST_SEC] = time_run;
    st_set[rtc_pkg::ST_TIME_EVENT_FLAG] = tev_hit;
    st_set[rtc_pkg::ST_CALENDAR_EVENT_FLAG] = cev_hit;
    st_set[rtc_pkg::ST_ALARM] = al_hit;
    // stop takes hold only on a second boundary
    if (tick && q.time_req && !q.time_stop)
      n.time_stop = 1'b1;
    if (tick && q.cal_req && !q.cal_stop)
      n.cal_stop = 1'b1;
    st_set[rtc_pkg::ST_ACK] = (n.time_stop && !q.time_stop) ||
                              (n.cal_stop && !q.cal_stop);
    // hour and calendar field decode of the merged write word
    wh = {2'b00, w[rtc_pkg::HOUR_LSB +: 6]};
    wcent = {1'b0, w[rtc_pkg::CENTURY_FIELD_LSB +: 7]};
    wyear = w[rtc_pkg::YEAR_LSB +: 8];
    wmonth = {3'b000, w[rtc_pkg::MONTH_LSB +: 5]};
    wday = w[rtc_pkg::DAY_LSB +: 3];
    wdate = {2'b00, w[rtc_pkg::DATE_LSB +: 6]};
    cal_ok = ((wcent == 8'h19) || (wcent == 8'h20)) &&
             bcd_rng(wyear, 8'h00, 8'h99) &&
             (wday >= 3'h1) && (wday <= 3'h7) &&
             bcd_rng(wmonth, 8'h01, 8'h12) &&
             bcd_rng(wdate, 8'h01, 8'h31) &&
             (wdate <= days_in(wmonth, wyear));
    if (req && wb_we_i)
    begin
      unique case (wb_adr_i[5:2])
        rtc_pkg::OFS_MODE[5:2]:
        begin
          n.time_req = w[rtc_pkg::TIME_UPD_BIT];
          n.cal_req = w[rtc_pkg::CAL_UPD_BIT];
          n.tev_sel = w[rtc_pkg::TEV_SEL_LSB +: 2];
          n.cev_sel = w[rtc_pkg::CEV_SEL_LSB +: 2];
          if (!w[rtc_pkg::TIME_UPD_BIT])
            n.time_stop = 1'b0;
          if (!w[rtc_pkg::CAL_UPD_BIT])
            n.cal_stop = 1'b0;
        end
        rtc_pkg::OFS_HOUR_MODE[5:2]:
          n.hour_fmt = w[rtc_pkg::HOUR_FMT_BIT];
        rtc_pkg::OFS_TIME[5:2]:
          if (q.time_stop)
          begin
            if (bcd_rng(w[rtc_pkg::SEC_LSB +: 8], 8'h00, 8'h59) &&
                bcd_rng(w[rtc_pkg::MIN_LSB +: 8], 8'h00, 8'h59) &&
                hour_ok(wh, w[rtc_pkg::HALF_DAY_BIT], q.hour_fmt))
            begin
              n.sec = w[rtc_pkg::SEC_LSB +: 8];
              n.min = w[rtc_pkg::MIN_LSB +: 8];
              n.hour = to_24(wh, w[rtc_pkg::HALF_DAY_BIT], q.hour_fmt);
              n.err[rtc_pkg::ERR_TIME] = 1'b0;
            end
            else
              n.err[rtc_pkg::ERR_TIME] = 1'b1;
          end
        rtc_pkg::OFS_CAL[5:2]:
          if (q.cal_stop)
          begin
            if (cal_ok)
            begin
              n.century_field = wcent;
              n.year = wyear;
              n.month = wmonth;
              n.day = wday;
              n.date = wdate;
              n.err[rtc_pkg::ERR_CAL] = 1'b0;
            end
            else
              n.err[rtc_pkg::ERR_CAL] = 1'b1;
          end
        rtc_pkg::OFS_TIME_ALARM[5:2]:
          if (bcd_rng({1'b0, w[rtc_pkg::SEC_LSB +: 7]}, 8'h00, 8'h59) &&
              bcd_rng({1'b0, w[rtc_pkg::MIN_LSB +: 7]}, 8'h00, 8'h59) &&
              hour_ok(wh, w[rtc_pkg::HALF_DAY_BIT], q.hour_fmt))
          begin
            n.al_sec = {1'b0, w[rtc_pkg::SEC_LSB +: 7]};
            n.al_sec_en = w[rtc_pkg::SEC_EN_BIT];
            n.al_min = {1'b0, w[rtc_pkg::MIN_LSB +: 7]};
            n.al_min_en = w[rtc_pkg::MIN_EN_BIT];
            n.al_hour = wh;
            n.al_pm = w[rtc_pkg::HALF_DAY_BIT];
            n.al_hour_en = w[rtc_pkg::HOUR_EN_BIT];
            n.err[rtc_pkg::ERR_TIME_ALARM] = 1'b0;
          end
          else
            n.err[rtc_pkg::ERR_TIME_ALARM] = 1'b1;
        rtc_pkg::OFS_CAL_ALARM[5:2]:
          if (bcd_rng(wmonth, 8'h01, 8'h12) &&
              bcd_rng(wdate, 8'h01, 8'h31))
          begin
            n.al_month = wmonth;
            n.al_month_en = w[rtc_pkg::MONTH_EN_BIT];
            n.al_date = wdate;
            n.al_date_en = w[rtc_pkg::DATE_EN_BIT];
            n.err[rtc_pkg::ERR_CAL_ALARM] = 1'b0;
          end
          else
            n.err[rtc_pkg::ERR_CAL_ALARM] = 1'b1;
        rtc_pkg::OFS_STATUS_CLEAR[5:2]: st_clr = w[4:0];
        rtc_pkg::OFS_IRQ_SET[5:2]: n.mask = q.mask | w[4:0];
        rtc_pkg::OFS_IRQ_CLEAR[5:2]: n.mask = q.mask & ~w[4:0];
        default: st_clr = 5'h0; // read-only and unmapped words swallow it
      endcase
    end
    // a new event beats a clear in the same cycle
    n.status = (q.status & ~st_clr) | st_set;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
      q.sec <= {1'b0, rtc_pkg::TIME_RESET[rtc_pkg::SEC_LSB +: 7]};
      q.min <= {1'b0, rtc_pkg::TIME_RESET[rtc_pkg::MIN_LSB +: 7]};
      q.hour <= {2'b00, rtc_pkg::TIME_RESET[rtc_pkg::HOUR_LSB +: 6]};
      q.century_field <= {1'b0, rtc_pkg::CAL_RESET[rtc_pkg::CENTURY_FIELD_LSB +: 7]};
      q.year <= rtc_pkg::CAL_RESET[rtc_pkg::YEAR_LSB +: 8];
      q.month <= {3'b000, rtc_pkg::CAL_RESET[rtc_pkg::MONTH_LSB +: 5]};
      q.day <= rtc_pkg::CAL_RESET[rtc_pkg::DAY_LSB +: 3];
      q.date <= {2'b00, rtc_pkg::CAL_RESET[rtc_pkg::DATE_LSB +: 6]};
    end
    else
      q <= n;
  end

endmodule

// *** testbench/rtc_bus_chk.sv ***
// checker for the bcd calendar clock: bus timing and readback shape.
// sees only the top module ports; bound to the design below.
`timescale 1ns/100ps
module rtc_bus_chk (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o
);
  logic take;
  assign take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  data_hold_a: assert property (!take |=> $stable(wb_dat_o))
    else $error("read data changed without request");
  mask_clear_a: assert property (take && wb_we_i && wb_adr_i == 6'h24
    && wb_sel_i[0] && wb_dat_i[4:0] == 5'h1f |=> !irq_o)
    else $error("irq stays after mask cleared");
  mask_shape_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == 6'h28 |-> wb_dat_o[31:5] == 27'h0)
    else $error("mask readback has stray bits");
  time_shape_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == 6'h08 |-> wb_dat_o[31:23] == 9'h0
    && wb_dat_o[6:4] <= 3'h5 && wb_dat_o[3:0] <= 4'h9 && !wb_dat_o[15])
    else $error("time readback not legal bcd");
  cal_shape_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == 6'h0c |-> wb_dat_o[23:21] != 3'h0
    && (wb_dat_o[7:0] == 8'h19 || wb_dat_o[7:0] == 8'h20))
    else $error("calendar readback out of range");
  err_shape_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) == 6'h2c |-> wb_dat_o[31:4] == 28'h0)
    else $error("entry error readback has stray bits");
  unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i[5:2]) > 4'hb |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind bcd_calendar_clock_alarm rtc_bus_chk rtc_bus_chk_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o));

// *** testbench/tb_top.sv ***
// self-checking bench for the bcd calendar clock over wishbone.
// assumes one-cycle ack; second divider shortened to SEC_CYC clocks.
`timescale 1ns/100ps
module tb_top;
  localparam int SEC_CYC = 20;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [31:0] keep;
  bcd_calendar_clock_alarm #(.SECOND_CYCLES(SEC_CYC))
    bcd_calendar_clock_alarm_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  always #50 clock_i = ~clock_i;
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clock_i);
    while (wb_ack_o !== 1'b1 && n < 40)
    begin
      @(posedge clock_i);
      n++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    check("bus ack", {31'h0, wb_ack_o}, 32'h1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [5:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q & m, exp);
  endtask
  // polls status; ticks every SEC_CYC clocks, so 80 polls is ample
  task automatic wait_stat(input logic [31:0] m);
    int n;
    n = 0;
    q = 32'h0;
    while ((q & m) !== m && n < 80)
    begin
      bus(1'b0, 6'h18, 32'h0);
      n++;
    end
  endtask
  task automatic start_update(input logic [31:0] req);
    wr(6'h00, req);
    wait_stat(32'h1);
    check("update ack", q & 32'h1, 32'h1);
    wr(6'h1c, 32'h1);
    rdc("ack cleared", 6'h18, 32'h1, 32'h0);
  endtask
  task automatic t_reset;
    logic [5:0] ofs [10];
    logic [31:0] e;
    ofs = '{6'h18, 6'h08, 6'h00, 6'h04, 6'h0c, 6'h10, 6'h14, 6'h28,
      6'h2c, 6'h30};
    foreach (ofs[i])
    begin
      e = (ofs[i] == rtc_pkg::OFS_CAL) ? rtc_pkg::CAL_RESET : 32'h0;
      rdc("reset value", ofs[i], 32'hffffffff, e);
    end
    $display("test reset values done");
  endtask
  task automatic t_time;
    logic [31:0] bad [5];
    bad = '{32'h60, 32'h6000, 32'h240000, 32'h400000, 32'ha};
    wr(6'h08, 32'h00235959);
    rdc("time while running", 6'h08, 32'h00ffff00, 32'h0);
    start_update(32'h1);
    bus(1'b0, 6'h08, 32'h0);
    keep = q;
    repeat (3 * SEC_CYC) @(posedge clock_i);
    rdc("time stopped", 6'h08, 32'hffffffff, keep);
    foreach (bad[i])
    begin
      wr(6'h08, bad[i]);
      rdc("bad time flag", 6'h2c, 32'h1, 32'h1);
      rdc("bad time kept", 6'h08, 32'hffffffff, keep);
    end
    wr(6'h04, 32'h1);
    wr(6'h08, 32'h00410000);
    rdc("pm hour", 6'h08, 32'hffffffff, 32'h00530000);
    wr(6'h04, 32'h0);
    wr(6'h08, 32'h00235958);
    rdc("legal time", 6'h08, 32'hffffffff, 32'h00235958);
    rdc("flag cleared", 6'h2c, 32'h1, 32'h0);
    wr(6'h20, 32'h8);
    rdc("mask set", 6'h28, 32'hffffffff, 32'h8);
    wr(6'h1c, 32'h1f);
    wr(6'h00, 32'h200);
    wait_stat(32'h8);
    check("midnight event", q & 32'h8, 32'h8);
    check("irq level", {31'h0, irq_o}, 32'h1);
    rdc("midnight", 6'h08, 32'hffffffff, 32'h0);
    rdc("next day", 6'h0c, 32'hffffffff, 32'h02a19819);
    wr(6'h24, 32'h8);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    $display("test time update done");
  endtask
  task automatic t_cal;
    logic [31:0] bad [6];
    bad = '{32'h01819821, 32'h01019819, 32'h01939819, 32'h32819819,
      32'h29820120, 32'h01819a19};
    start_update(32'h2);
    bus(1'b0, 6'h08, 32'h0);
    keep = q;
    repeat (2 * SEC_CYC) @(posedge clock_i);
    bus(1'b0, 6'h08, 32'h0);
    check("time runs", {31'h0, q != keep}, 32'h1);
    wr(6'h0c, 32'h29820019);
    rdc("leap 1900", 6'h0c, 32'hffffffff, 32'h29820019);
    keep = q;
    foreach (bad[i])
    begin
      wr(6'h0c, bad[i]);
      rdc("bad cal flag", 6'h2c, 32'h2, 32'h2);
      rdc("bad cal kept", 6'h0c, 32'hffffffff, keep);
    end
    wr(6'h0c, 32'h29820020);
    rdc("leap 2000", 6'h0c, 32'hffffffff, 32'h29820020);
    rdc("cal flag cleared", 6'h2c, 32'h2, 32'h0);
    start_update(32'h3);
    wr(6'h08, 32'h00235959);
    wr(6'h0c, 32'h28820120);
    wr(6'h1c, 32'h1f);
    wr(6'h00, 32'h10000);
    wait_stat(32'h10);
    check("month event", q & 32'h10, 32'h10);
    rdc("march first", 6'h0c, 32'hffffffff, 32'h01a30120);
    $display("test calendar update done");
  endtask
  task automatic t_alarm;
    start_update(32'h1);
    wr(6'h08, 32'h00000010);
    wr(6'h10, 32'h000000e0);
    rdc("bad alarm flag", 6'h2c, 32'h4, 32'h4);
    wr(6'h10, 32'h00000095);
    wr(6'h1c, 32'h1f);
    wr(6'h00, 32'h0);
    wait_stat(32'h2);
    check("alarm flag", q & 32'h2, 32'h2);
    rdc("alarm second", 6'h08, 32'hffffffff, 32'h00000015);
    $display("test alarm done");
  endtask
  // noon and year events, century wrap, repeated reads, mask clear
  task automatic t_events;
    logic [31:0] prev;
    int n;
    start_update(32'h3);
    wr(6'h08, 32'h00115959);
    wr(6'h0c, 32'h31f29920);
    wr(6'h1c, 32'h1f);
    wr(6'h00, 32'h20300);
    wait_stat(32'h8);
    check("noon event", q & 32'h18, 32'h8);
    // time runs on, so read until two reads agree, three at most
    bus(1'b0, 6'h08, 32'h0);
    n = 1;
    do
    begin
      prev = q;
      bus(1'b0, 6'h08, 32'h0);
      n++;
    end
    while (q !== prev && n < 3);
    check("stable time read", q, 32'h00120000);
    start_update(32'h3);
    wr(6'h08, 32'h00235959);
    wr(6'h1c, 32'h1f);
    wr(6'h00, 32'h20100);
    wait_stat(32'h10);
    check("hour event", q & 32'h8, 32'h8);
    check("year event", q & 32'h10, 32'h10);
    rdc("century wrap", 6'h0c, 32'hffffffff, 32'h01210019);
    wr(6'h20, 32'h1f);
    check("irq all set", {31'h0, irq_o}, 32'h1);
    wr(6'h24, 32'h1f);
    check("irq all cleared", {31'h0, irq_o}, 32'h0);
    $display("test events done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // whole run needs under a thousand clocks; ceiling leaves wide margin
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_time();
    t_cal();
    t_alarm();
    t_events();
    finish_test();
  end
endmodule
